// ### inc/sbc_spi_defines.svh
// Operation
// - frames need 0, 16 or 32 clocks
// - error bit leads next frame's output
// - frames opening or closing with reset low set error
// - output forced high while reset low
// - zero-clock frame polls the error bit
// - fail-safe entry cuts the frame off
// - address low, selector, data high
// - selector picks read/clear or write/read
// - status bits clear only by command
// - restart mode ignores all frames
// - addressed byte returned in same frame
// - writes commit when select rises
// - stop mode: normal, watchdog, status
// - level-zero lock guards pump and pins
// - level-one lock freezes until power-up
// - late status change shows next frame
// - summary bit mirrors register nonzero
// - summary bit to register mapping
// - 32-bit frames only in wake range
// - gaps redirect, overflow bytes read zero
// - sample falling edge, shift rising
// - interpret and release on select rise
// - control: selector one also writes
// - upper addresses decode as status
`ifndef SBC_SPI_DEFINES_SVH
`define SBC_SPI_DEFINES_SVH
`define CNT_W          6
`define CNT_MAX        6'h3f
`define CLK_NONE       6'h00
`define CLK_16         6'h10
`define CLK_32         6'h20
`define ACC_BIT        7
`define CTRL_TOP       7'h3f
`define SWK_LO         7'h20
`define STAT_LO        7'h40
`define STAT_HI        7'h7e
`define GAP_ADDR       7'h1f
`define MODE_CTRL_ADDR 7'h01
`define MODE_NORMAL    2'h0
`define WDOG_ADDR      7'h03
`define CPEN_ADDR      7'h02
`define CPEN_BIT       5
`define HWC1_ADDR      7'h0e
`define HWC2_ADDR      7'h0f
`define LOCK0_BIT      3
`define LOCK1_BIT      0
`define GPIO_ADDR      7'h11
`define CAL_HI_ADDR    7'h3c
`define CAL_LO_ADDR    7'h3d
`define WKLVL_ADDR     7'h48
`define SUM0_ADDR      7'h41
`define SUM1_ADDR      7'h42
`define SUM2_ADDR      7'h43
`define SUM3_ADDR      7'h44
`define SUM4A_ADDR     7'h46
`define SUM4B_ADDR     7'h47
`define SUM5_ADDR      7'h40
`define SUM6_ADDR      7'h54
`define SUM7_ADDR      7'h55
`define REG_RST        8'h00
`endif

// ### inc/sbc_spi_pkg.sv
`default_nettype none
package sbc_spi_pkg;
  // operating mode of the chip, one-hot
  typedef enum logic [5:0] {
    MODE_INIT     = 6'h01,
    MODE_NORMAL   = 6'h02,
    MODE_STOP     = 6'h04,
    MODE_SLEEP    = 6'h08,
    MODE_RESTART  = 6'h10,
    MODE_FAILSAFE = 6'h20
  } mode_t;
  // byte-wide register image
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ### rtl/sbc_spi_command_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_spi_defines.svh"
module sbc_spi_command_port
  import sbc_spi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       spi_clk,
  input  wire logic       chip_select_low,
  input  wire logic       serial_in_line,
  input  wire logic       reset_output_pin,
  input  wire mode_t      device_mode,
  input  wire logic       status_set_valid,
  input  wire logic [6:0] status_set_addr,
  input  wire logic [7:0] status_set_bits,
  output logic            serial_out_line,
  output logic            serial_out_oe,
  output logic            err_flag,
  output logic [7:0]      status_summary_byte,
  output logic            wr_strobe,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);

  // register image, control and status together
  // one array keeps reads and writes in one place; the link side
  // reads it directly, which is safe only because control bytes
  // change at frame close, while the link clock stands still
  byte_t mem [0:127];

  // redirect gaps to next register; bit 7 marks a valid address
  // a zero result means nothing is there: reads give 0, writes drop
  function automatic logic [7:0] redir(input logic [6:0] a);
    if (a == `GAP_ADDR) begin
      redir = {1'b1, `SWK_LO};
    end else if (a > `STAT_HI) begin
      redir = 8'h00;
    end else begin
      redir = {1'b1, a};
    end
  endfunction

  // status or read-only calibration register
  // calibration bytes sit in the control range but are read-only
  function automatic logic is_stat(input logic [6:0] a);
    is_stat = (a >= `STAT_LO) || (a == `CAL_HI_ADDR) || (a == `CAL_LO_ADDR);
  endfunction

  // serial port active in these modes
  // sleep, restart and fail-safe leave every frame uninterpreted
  function automatic logic mode_on(input mode_t m);
    mode_on = (m == MODE_INIT) || (m == MODE_NORMAL) || (m == MODE_STOP);
  endfunction

  // status summary from the register image
  // bit 4 covers both wake source registers
  function automatic logic [7:0] summary();
    summary[0] = |mem[`SUM0_ADDR];
    summary[1] = |mem[`SUM1_ADDR];
    summary[2] = |mem[`SUM2_ADDR];
    summary[3] = |mem[`SUM3_ADDR];
    summary[4] = |(mem[`SUM4A_ADDR] | mem[`SUM4B_ADDR]);
    summary[5] = |mem[`SUM5_ADDR];
    summary[6] = |mem[`SUM6_ADDR];
    summary[7] = |mem[`SUM7_ADDR];
  endfunction

  // bits of a byte that locks keep unchanged
  // level one wins over level zero; a locked bit keeps its old
  // value while the rest of the byte still takes the new data
  function automatic logic [7:0] keep_mask(input logic [6:0] a);
    keep_mask = 8'h00;
    if (mem[`HWC2_ADDR][`LOCK1_BIT] && ((a == `HWC1_ADDR) || (a == `HWC2_ADDR))) begin
      keep_mask = 8'hff;
    end else if (mem[`HWC1_ADDR][`LOCK0_BIT] && (a == `GPIO_ADDR)) begin
      keep_mask = 8'hff;
    end else if (mem[`HWC1_ADDR][`LOCK0_BIT] && (a == `CPEN_ADDR)) begin
      keep_mask = 8'h01 << `CPEN_BIT;
    end
  endfunction

  // ---------------- link domain ----------------
  // these flops run on the host's clock (summ_snap excepted, it runs on mclk);
  // select high clears the start and output flags, the counter and shifter
  // restart on the first edge; no system reset reaches them, so the first frame
  // after power-up relies on select having been high once before it;
  // the clock must be parked low between frames
  logic                started_lk;   // first falling edge seen
  logic [`CNT_W-1:0]   cnt_lk;       // falling edges in frame
  logic [31:0]         rx_lk;        // received word
  logic                tx_live;      // first rising edge seen
  logic                tx_bit;       // shifted output bit
  logic [`CNT_W-1:0]   idx;          // output bit position
  logic                resp_bit;     // next output bit
  logic [7:0]          summ_snap;    // summary frozen per frame

  // frame start flag, cleared while deselected
  // also tells the counter and shifter to restart on the first edge
  always_ff @(negedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      started_lk <= 1'b0;
    end else begin
      started_lk <= 1'b1;
    end
  end

  // clock counter, restarts on first edge, saturates
  // saturation keeps an overlong frame from wrapping back to 16 or 32
  always_ff @(negedge spi_clk) begin
    if (!started_lk) begin
      cnt_lk <= 6'h01;
    end else if (cnt_lk != `CNT_MAX) begin
      cnt_lk <= cnt_lk + 6'h01;
    end
  end

  // input shift, sampled on falling edge
  // bit n of the word lands at falling edge n+1, lsb first
  // bits past 32 are dropped, the counter still marks the overrun
  always_ff @(negedge spi_clk) begin
    if (!started_lk) begin
      rx_lk <= {31'h0, serial_in_line};
    end else if (cnt_lk < `CLK_32) begin
      rx_lk[cnt_lk[4:0]] <= serial_in_line;
    end
  end

  // response bit for the current position
  // positions 0..7 carry the frozen summary, 8..31 up to three bytes;
  // the address is complete after seven falling edges, well before
  // the first data bit is launched at the ninth rising edge
  always_comb begin
    logic [7:0] rb;
    logic [7:0] b;
    logic [7:0] s;
    logic [1:0] k;
    rb = redir(rx_lk[6:0]);
    idx = started_lk ? cnt_lk : `CLK_NONE;
    k = 2'(({2'h0, idx} - 8'h08) >> 3);
    s = {1'b0, rb[6:0]} + {6'h0, k};
    b = mem[s[6:0]];
    if (!rb[7] || ((k != 2'h0) && (s > {1'b0, `CTRL_TOP}))) begin
      b = 8'h00;
    end
    if (idx < 6'h08) begin
      resp_bit = summ_snap[idx[2:0]];
    end else if (idx < `CLK_32) begin
      resp_bit = b[idx[2:0]];
    end else begin
      resp_bit = 1'b0;
    end
  end

  // output shift after each rising edge
  // launched at the rising edge so the host samples it at the falling one
  always_ff @(posedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      tx_live <= 1'b0;
      tx_bit  <= 1'b0;
    end else begin
      tx_live <= 1'b1;
      tx_bit  <= resp_bit;
    end
  end

  // output: forced high in reset, error before first edge
  // the error flag is a system-domain flop held steady for the whole
  // frame, so showing it on the line before any edge is safe
  assign serial_out_line = !reset_output_pin ? 1'b1 :
                           tx_live ? tx_bit : err_flag;

  // ---------------- system domain ----------------
  // everything below runs on mclk; select, link clock and the start
  // flag enter only through the two-stage synchronisers
  logic cs_meta;   // select, first stage
  logic cs_sync;   // select, synchronised
  logic ck_meta;   // clock level, first stage
  logic ck_sync;   // clock level, synchronised
  logic st_meta;   // frame start, first stage
  logic st_sync;   // frame start, synchronised
  logic cs_prev;   // select, last cycle
  logic rst_start; // reset pin level at frame start
  logic ck_bad;    // clock high at falling select
  logic saw;       // clocks seen in frame
  logic cut;       // fail-safe hit the frame

  // two-stage synchronisers
  // select resets high and clock low, matching the idle pins,
  // so no false frame edge follows a reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      st_meta <= 1'b0;
      st_sync <= 1'b0;
    end else if (ce) begin
      cs_meta <= chip_select_low;
      cs_sync <= cs_meta;
      ck_meta <= spi_clk;
      ck_sync <= ck_meta;
      st_meta <= started_lk;
      st_sync <= st_meta;
    end
  end

  // frame edges seen on the synchronised select, about two cycles late
  logic fall; // frame opens
  logic rise; // frame closes
  assign fall = ce && cs_prev && !cs_sync;
  assign rise = ce && !cs_prev && cs_sync;

  // frame supervision
  // captures reset pin, clock level and mode at the opening edge, then
  // watches for clocks and fail-safe entry until the frame closes;
  // the link counter itself is read only once the frame has closed
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_prev   <= 1'b1;
      rst_start <= 1'b1;
      ck_bad    <= 1'b0;
      saw       <= 1'b0;
      cut       <= 1'b0;
    end else if (ce) begin
      cs_prev <= cs_sync;
      if (fall) begin
        rst_start <= reset_output_pin;
        ck_bad    <= ck_sync;
        saw       <= st_sync;
        cut       <= device_mode == MODE_FAILSAFE;
      end else if (!cs_sync) begin
        if (st_sync) begin
          saw <= 1'b1;
        end
        if (device_mode == MODE_FAILSAFE) begin
          cut <= 1'b1;
        end
      end
    end
  end

  // decode of the closing frame, up to three byte actions
  logic [`CNT_W-1:0] nclk;   // clocks in closed frame
  logic              bad;    // frame in error
  logic              go;     // frame to interpret
  logic              wide;   // 32-bit frame
  logic              acc;    // access selector
  logic [7:0]        base;   // resolved address
  logic [6:0]        ta [0:2];   // byte addresses
  logic              tv [0:2];   // byte in range and frame accepted
  logic              twr [0:2];  // byte written
  logic              tclr [0:2]; // byte cleared
  logic [7:0]        tval [0:2]; // value after lock merge

  // decode closing frame into byte actions
  // only the cycle of rise can produce actions, so every byte action
  // is a single-cycle pulse; bad frames and idle modes yield none
  always_comb begin
    logic [7:0] s;
    logic [7:0] d;
    logic       perm;
    s    = 8'h00;
    d    = 8'h00;
    perm = 1'b0;
    nclk = (saw || st_sync) ? cnt_lk : `CLK_NONE;
    bad  = !((nclk == `CLK_NONE) || (nclk == `CLK_16) || (nclk == `CLK_32))
           || ck_bad || ck_sync
           || !rst_start || !reset_output_pin
           || cut;
    wide = nclk == `CLK_32;
    acc  = rx_lk[`ACC_BIT];
    base = redir(rx_lk[6:0]);
    go   = rise && !bad && (nclk != `CLK_NONE) && base[7]
           && mode_on(device_mode);
    if (wide && ((base[6:0] < `SWK_LO) || (base[6:0] > `CTRL_TOP)
        || (base[6:0] == `CAL_HI_ADDR) || (base[6:0] == `CAL_LO_ADDR))) begin
      go = 1'b0;
    end
    for (int k = 0; k < 3; k++) begin
      s = {1'b0, base[6:0]} + 8'(k);
      d = rx_lk[8 + 8 * k +: 8];
      ta[k] = s[6:0];
      tv[k] = go && ((k == 0) || (wide && (s <= {1'b0, `CTRL_TOP})));
      perm  = (device_mode != MODE_STOP)
              || ((s[6:0] == `MODE_CTRL_ADDR) && (d[7:6] == `MODE_NORMAL))
              || (s[6:0] == `WDOG_ADDR);
      tclr[k] = tv[k] && acc && is_stat(s[6:0]) && (s[6:0] != `WKLVL_ADDR)
                && (s[6:0] != `CAL_HI_ADDR) && (s[6:0] != `CAL_LO_ADDR);
      twr[k]  = tv[k] && acc && !is_stat(s[6:0]) && perm;
      tval[k] = (mem[s[6:0]] & keep_mask(s[6:0]))
                | (d & ~keep_mask(s[6:0]));
    end
  end

  // register image: commits at select rise, status set wins
  // a status event landing in the very cycle of a clear keeps its bits,
  // while one landing after the byte was read but before that cycle is cleared unread
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= `REG_RST;
      end
    end else if (ce) begin
      for (int k = 0; k < 3; k++) begin
        if (tclr[k]) begin
          mem[ta[k]] <= 8'h00;
        end else if (twr[k]) begin
          mem[ta[k]] <= tval[k];
        end
      end
      if (status_set_valid && is_stat(status_set_addr)) begin
        if ((tclr[0] && ta[0] == status_set_addr) || (tclr[1] && ta[1] == status_set_addr)
            || (tclr[2] && ta[2] == status_set_addr)) begin
          mem[status_set_addr] <= status_set_bits;
        end else begin
          mem[status_set_addr] <= mem[status_set_addr] | status_set_bits;
        end
      end
    end
  end

  // error flag, updated at each frame close
  // a clean frame, a zero-clock poll included, clears it again
  always_ff @(posedge mclk) begin
    if (srst) begin
      err_flag <= 1'b0;
    end else if (rise) begin
      err_flag <= bad;
    end
  end

  // summary frozen while a frame runs
  // a status change during a frame shows in the next frame's summary;
  // the register itself is already set
  always_ff @(posedge mclk) begin
    if (srst) begin
      summ_snap <= 8'h00;
    end else if (ce && cs_sync) begin
      summ_snap <= summary();
    end
  end
  assign status_summary_byte = summ_snap;

  // output enable, released when deselected
  // lags select by about three cycles; the line is undriven outside
  // frames and in sleep and fail-safe; restart mode still drives it
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_out_oe <= 1'b0;
    end else if (ce) begin
      serial_out_oe <= !cs_sync && (device_mode != MODE_FAILSAFE)
                       && (device_mode != MODE_SLEEP);
    end
  end

  // first written byte reported to mode logic
  // only the first byte of a frame is reported; wide frames still
  // commit their further bytes in the image
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_strobe <= 1'b0;
      wr_addr   <= 7'h00;
      wr_data   <= 8'h00;
    end else if (ce) begin
      wr_strobe <= twr[0];
      if (twr[0]) begin
        wr_addr <= ta[0];
        wr_data <= tval[0];
      end
    end else begin
      wr_strobe <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### tb/sbc_spi_command_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_spi_defines.svh"
module sbc_spi_command_port_monitor (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       spi_clk,
  input wire logic       chip_select_low,
  input wire logic       reset_output_pin,
  input wire logic       status_set_valid,
  input wire logic [6:0] status_set_addr,
  input wire logic [7:0] status_set_bits,
  input wire logic       serial_out_line,
  input wire logic       serial_out_oe,
  input wire logic       err_flag,
  input wire logic [7:0] status_summary_byte,
  input wire logic       wr_strobe,
  input wire logic [6:0] wr_addr
);
  // high once the first link clock of a frame has risen
  logic seen_rise;
  always_ff @(posedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      seen_rise <= 1'b0;
    end else begin
      seen_rise <= 1'b1;
    end
  end
  chk_out_forced: assert property (@(posedge mclk) disable iff (srst)
    !reset_output_pin |-> serial_out_line) else $error("output low while reset pin low");
  chk_oe_release: assert property (@(posedge mclk) disable iff (srst)
    chip_select_low [*5] |-> !serial_out_oe) else $error("output still driven after close");
  chk_strobe_once: assert property (@(posedge mclk) disable iff (srst)
    wr_strobe |=> !wr_strobe) else $error("write strobe longer than one cycle");
  chk_strobe_close: assert property (@(posedge mclk) disable iff (srst)
    wr_strobe |-> chip_select_low && $past(chip_select_low)) else $error("write inside frame");
  chk_strobe_ctrl: assert property (@(posedge mclk) disable iff (srst)
    wr_strobe |-> wr_addr <= `CTRL_TOP) else $error("write to status address");
  chk_err_steady: assert property (@(posedge mclk) disable iff (srst)
    err_flag != $past(err_flag) |-> chip_select_low && $past(chip_select_low))
    else $error("error flag moved inside frame");
  chk_sum_frozen: assert property (@(posedge mclk) disable iff (srst)
    !chip_select_low [*4] |-> $stable(status_summary_byte)) else $error("summary moved in frame");
  chk_sum_map: assert property (@(posedge mclk) disable iff (srst)
    chip_select_low [*5] ##0 (status_set_valid && ce && status_set_addr == `SUM0_ADDR &&
    status_set_bits != 8'h00) ##1 chip_select_low [*3] |-> status_summary_byte[0])
    else $error("summary bit zero not set");
  chk_err_lead: assert property (@(posedge spi_clk) disable iff (srst)
    !chip_select_low && !seen_rise && reset_output_pin |-> serial_out_line == err_flag)
    else $error("error bit not leading the frame");
  cov_write: cover property (@(posedge mclk) wr_strobe);
  cov_err: cover property (@(posedge mclk) $rose(err_flag));
  cov_wake: cover property (@(posedge mclk) status_summary_byte[4]);
endmodule
bind sbc_spi_command_port sbc_spi_command_port_monitor sbc_spi_command_port_monitor_inst (
  .mclk(mclk), .srst(srst), .ce(ce), .spi_clk(spi_clk), .chip_select_low(chip_select_low),
  .reset_output_pin(reset_output_pin), .status_set_valid(status_set_valid),
  .status_set_addr(status_set_addr), .status_set_bits(status_set_bits),
  .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .err_flag(err_flag),
  .status_summary_byte(status_summary_byte), .wr_strobe(wr_strobe), .wr_addr(wr_addr));
`default_nettype wire

// ### tb/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host master: runs frames with a 6 ns link clock, parked low between frames
module spi_host_model (
  output var logic        spi_clk,
  output var logic        chip_select_low,
  output var logic        serial_in_line,
  input  wire logic       serial_out_line,
  output var logic [31:0] rx,
  output var logic        err_seen,
  output var logic        done
);
  // idle state: select high, clock low
  initial begin
    spi_clk         = 1'b0;
    chip_select_low = 1'b0;
    serial_in_line  = 1'b0;
    rx              = 32'h0;
    err_seen        = 1'b0;
    done            = 1'b0;
    // a short select pulse clears the link flags before the first frame
    #1 chip_select_low = 1'b1;
  end
  // one frame of n clocks, word sent lsb first
  task automatic xfer(input int n, input logic [31:0] w);
    rx              = 32'h0;
    chip_select_low = 1'b0;
    serial_in_line  = w[0];
    #100;
    err_seen = serial_out_line;
    for (int k = 1; k <= n; k++) begin
      #3 spi_clk = 1'b1;
      #1 serial_in_line = w[(k - 1) % 32];
      #2 spi_clk = 1'b0;
      rx[k - 1] = serial_out_line;
    end
    #10 chip_select_low = 1'b1;
    // a released data line must not keep its last level
    serial_in_line = ~serial_in_line;
    #150 done = 1'b1;
    #1 done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbc_spi_defines.svh"
module testbench import sbc_spi_pkg::*; ;
  localparam logic [32:0] ERRC = {1'b1, 32'h0};
  localparam logic [32:0] C16  = {1'b1, 32'h0000ffff};
  logic        mclk, srst, ce, rst_pin, set_valid;
  logic [6:0]  set_addr;
  logic [7:0]  set_bits, d, dm, b0, b1;
  mode_t       mode;
  wire         spi_clk, chip_select_low, serial_in_line, serial_out_line, err_seen, done;
  wire         wr_strobe, err_flag;
  wire  [31:0] rx;
  wire  [7:0]  wr_data;
  wire  [6:0]  wr_addr;
  logic [32:0] rx_exp [$];
  logic [32:0] rx_care [$];
  logic [14:0] wr_exp [$];
  int          miscompares, checked;
  logic [31:0] seed;
  logic [6:0]  sa [9] = '{`SUM0_ADDR, `SUM1_ADDR, `SUM2_ADDR, `SUM3_ADDR, `SUM4A_ADDR,
                          `SUM4B_ADDR, `SUM5_ADDR, `SUM6_ADDR, `SUM7_ADDR};
  int          sb [9] = '{0, 1, 2, 3, 4, 4, 5, 6, 7};
  mode_t       ml [3] = '{MODE_STOP, MODE_SLEEP, MODE_RESTART};
  sbc_spi_command_port sbc_spi_command_port_inst (.mclk(mclk), .srst(srst), .ce(ce),
    .spi_clk(spi_clk), .chip_select_low(chip_select_low), .serial_in_line(serial_in_line),
    .reset_output_pin(rst_pin), .device_mode(mode), .status_set_valid(set_valid),
    .status_set_addr(set_addr), .status_set_bits(set_bits), .serial_out_line(serial_out_line),
    .serial_out_oe(), .err_flag(err_flag), .status_summary_byte(), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data));
  spi_host_model spi_host_model_inst (.spi_clk(spi_clk), .chip_select_low(chip_select_low),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .rx(rx),
    .err_seen(err_seen), .done(done));
  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // 16-bit command word: data, selector, address
  function automatic logic [31:0] cmd(input logic [6:0] a, input logic s, input logic [7:0] v);
    return {16'h0, v, s, a};
  endfunction
  task automatic cmp_rx(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] care);
    checked++;
    if (((got ^ exp) & care) !== 33'h0) begin
      miscompares++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [14:0] got, input logic [14:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t write %h expected %h", $time, got, exp);
    end
  endtask
  // note the expected answer, then run the frame
  task automatic frame(input int n, input logic [31:0] w,
                       input logic [32:0] e, input logic [32:0] c);
    rx_exp.push_back(e);
    rx_care.push_back(c);
    spi_host_model_inst.xfer(n, w);
  endtask
  task automatic summarize();
    if (rx_exp.size() != 0 || wr_exp.size() != 0) begin
      miscompares++;
    end
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // response watcher
  always @(posedge done) begin
    cmp_rx({err_seen, rx}, rx_exp.pop_front(), rx_care.pop_front());
  end
  // write watcher, any unexpected write strobe is a mismatch
  always @(negedge mclk) begin
    if (wr_strobe === 1'b1) begin
      if (wr_exp.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t unexpected write", $time);
      end else begin
        cmp_wr({wr_addr, wr_data}, wr_exp.pop_front());
      end
    end
  end
  initial begin
    #100000;
    miscompares++;
    $display("[FAIL] %0t timeout", $time);
    summarize();
  end
  initial begin
    {srst, ce, rst_pin, set_valid, set_addr, set_bits} = {3'b111, 16'h0};
    mode = MODE_NORMAL;
    {seed, miscompares, checked} = {32'hb6d6f8e4, 64'h0};
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    frame(0, 32'h0, 33'h0, ERRC);
    seed = lfsr(seed);
    d = seed[7:0];
    wr_exp.push_back({`CPEN_ADDR, d});
    frame(16, cmd(`CPEN_ADDR, 1'b1, d), 33'h0, C16);
    frame(16, cmd(`CPEN_ADDR, 1'b0, 8'h00), {17'h0, d, 8'h00}, C16);
    wr_exp.push_back({`HWC1_ADDR, 8'h08});
    frame(16, cmd(`HWC1_ADDR, 1'b1, 8'h08), 33'h0, ERRC);
    dm = (~d & 8'hdf) | (d & 8'h20);
    wr_exp.push_back({`CPEN_ADDR, dm});
    frame(16, cmd(`CPEN_ADDR, 1'b1, ~d), {17'h0, d, 8'h00}, C16);
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk) mode = ml[i];
      frame(16, cmd(`CPEN_ADDR, 1'b1, 8'h5a), 33'h0, 33'h0);
    end
    @(negedge mclk) mode = MODE_STOP;
    wr_exp.push_back({`MODE_CTRL_ADDR, 8'h00});
    frame(16, cmd(`MODE_CTRL_ADDR, 1'b1, 8'h00), 33'h0, 33'h0);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      @(negedge mclk) {set_valid, set_addr, set_bits} = {1'b1, sa[i], seed[7:0] | 8'h01};
      b0 = set_bits;
      @(negedge mclk) set_valid = 1'b0;
      repeat (3) @(negedge mclk);
      frame(16, cmd(sa[i], 1'b1, 8'h00), {17'h0, b0, 8'h01 << sb[i]}, C16);
      frame(16, cmd(sa[i], 1'b0, 8'h00), 33'h0, C16);
    end
    @(negedge mclk) mode = MODE_NORMAL;
    frame(16, cmd(`CPEN_ADDR, 1'b0, 8'h00), {17'h0, dm, 8'h00}, {17'h0, 16'hff00});
    frame(15, cmd(`CPEN_ADDR, 1'b1, 8'h00), 33'h0, ERRC);
    frame(0, 32'h0, ERRC, ERRC);
    frame(0, 32'h0, 33'h0, ERRC);
    @(negedge mclk) mode = MODE_INIT;
    seed = lfsr(seed);
    d = seed[7:0];
    wr_exp.push_back({7'h05, d});
    frame(16, cmd(7'h05, 1'b1, d), 33'h0, ERRC);
    @(negedge mclk) mode = MODE_FAILSAFE;
    frame(16, cmd(7'h05, 1'b1, 8'h00), 33'h0, ERRC);
    @(negedge mclk) mode = MODE_NORMAL;
    frame(0, 32'h0, ERRC, ERRC);
    frame(16, cmd(7'h05, 1'b0, 8'h00), {17'h0, d, 8'h00}, C16);
    @(negedge mclk) rst_pin = 1'b0;
    frame(16, cmd(`CPEN_ADDR, 1'b1, 8'h00), C16, C16);
    fork
      frame(16, cmd(`CPEN_ADDR, 1'b1, 8'h00), ERRC, ERRC);
      begin
        repeat (6) @(negedge mclk);
        rst_pin = 1'b1;
      end
    join
    frame(0, 32'h0, ERRC, ERRC);
    seed = lfsr(seed);
    {b1, b0} = seed[15:0];
    wr_exp.push_back({7'h3e, b0});
    frame(32, {8'h00, b1, b0, 1'b1, 7'h3e}, 33'h0, ERRC);
    frame(32, {24'h0, 1'b0, 7'h3e}, {9'h0, b1, b0, 8'h00}, 33'h1ffffffff);
    frame(32, {16'hffff, 8'hff, 1'b1, `CPEN_ADDR}, 33'h0, ERRC);
    repeat (10) @(negedge mclk);
    summarize();
  end
endmodule
`default_nettype wire
